// ### hli_irq_top.sv
// Purpose: interrupt mask and isochronous transmit event logic
// Assumes: one clock, register port answers one cycle after a read strobe
// Notes:   latched main events arrive from outside; bit 6 is built here
// Function
// - mask read at either offset, no side effects
// - mask bits set/cleared by writing ones
// - mask bits below 30 gate same event
// - gate bit 31 low blocks external interrupt
// - maker interrupt needs mask30 and event30
// - software interrupt needs mask29 and event29
// - bits 27..20 need mask and event
// - bits 19..15 need mask and event
// - bits 9..0 need mask and event
// - reserved mask bits read zero, ignore writes
// - context final output completion raises flag
// - flag set by request edge or write
// - flag cleared only by clear write
// - tx clear read returns events AND mask
// - eight flags in bits 7..0, rest zero
// - event bit 6 is OR of masked flags
// - main event read returns events AND mask
// - tx mask register with set/clear offsets
`timescale 1ns/1ns
`default_nettype none
module hli_irq_top
  import hli_pkg::*;
(
  input  wire logic                  mclk,                 // 20 MHz clock
  input  wire logic                  srst,                 // sync reset, high
  input  wire hli_pkg::hli_bus_t     bus,                  // register port request
  output logic        [31:0]         rd_data,              // read data, cycle after rd
  input  wire logic   [31:0]         main_event_in,        // latched main event bits
  input  wire logic   [7:0]          tx_ctx_irq,           // context completion requests
  output logic                       irq,                  // external interrupt level
  output logic                       maker_extra_irq,      // maker extra interrupt
  output logic                       software_raised_irq,  // software raised interrupt
  output logic                       iso_tx_summary,       // unlatched tx summary
  output logic        [7:0]          tx_context_flag       // tx context flags
);
  import hli_pkg::*;

  hli_top_st_t st;
  hli_top_st_t next_st;

  logic [31:0] mask;
  logic [7:0]  tx_mask;
  logic [7:0]  tx_ev;
  logic [7:0]  tx_rise;
  logic [31:0] mask_set;
  logic [31:0] mask_clr;
  logic [7:0]  txev_set;
  logic [7:0]  txev_clr;
  logic [7:0]  txmk_set;
  logic [7:0]  txmk_clr;
  logic        tx_sum_now;
  logic [31:0] ev_eff;
  logic [31:0] ev_masked;

  // write decode; zero writes leave bits alone
  always_comb begin
    mask_set = (bus.wr && bus.addr == HLI_OFS_MASK_SET) ? bus.wdata : HLI_RD_ZERO;
    mask_clr = (bus.wr && bus.addr == HLI_OFS_MASK_CLR) ? bus.wdata : HLI_RD_ZERO;
    txev_set = (bus.wr && bus.addr == HLI_OFS_TXEV_SET) ? bus.wdata[7:0] : HLI_TX_RST;
    txev_clr = (bus.wr && bus.addr == HLI_OFS_TXEV_CLR) ? bus.wdata[7:0] : HLI_TX_RST;
    txmk_set = (bus.wr && bus.addr == HLI_OFS_TXMK_SET) ? bus.wdata[7:0] : HLI_TX_RST;
    txmk_clr = (bus.wr && bus.addr == HLI_OFS_TXMK_CLR) ? bus.wdata[7:0] : HLI_TX_RST;
  end

  // main mask; no hardware path into it, gate bit included
  hli_setclr_reg #(
    .W   (32),
    .RW  (HLI_MASK_RW),
    .RST (HLI_MASK_RST)
  ) u_mask (
    .mclk   (mclk),
    .srst   (srst),
    .sw_set (mask_set),
    .sw_clr (mask_clr),
    .hw_set (HLI_RD_ZERO),
    .q      (mask)
  );

  hli_setclr_reg #(
    .W   (8),
    .RW  (HLI_TX_RW),
    .RST (HLI_TX_RST)
  ) u_txmask (
    .mclk   (mclk),
    .srst   (srst),
    .sw_set (txmk_set),
    .sw_clr (txmk_clr),
    .hw_set (HLI_TX_RST),
    .q      (tx_mask)
  );

  // completion requests latch on their rising edge only
  hli_edge_det #(
    .W (8)
  ) u_edge (
    .mclk (mclk),
    .srst (srst),
    .lvl  (tx_ctx_irq),
    .rise (tx_rise)
  );

  hli_setclr_reg #(
    .W   (8),
    .RW  (HLI_TX_RW),
    .RST (HLI_TX_RST)
  ) u_txev (
    .mclk   (mclk),
    .srst   (srst),
    .sw_set (txev_set),
    .sw_clr (txev_clr),
    .hw_set (tx_rise),
    .q      (tx_ev)
  );

  always_comb begin
    tx_sum_now = |(tx_ev & tx_mask);
    ev_eff = main_event_in;
    ev_eff[HLI_BIT_ISOTX] = tx_sum_now;
    ev_eff[HLI_BIT_GATE] = 1'b0;
    // each enable lines up with its own event bit
    ev_masked = ev_eff & mask & HLI_MASK_RW;
  end

  always_comb begin
    next_st = st;
    next_st.tx_sum = tx_sum_now;
    // gate off keeps the pin low whatever else is enabled
    next_st.irq = mask[HLI_BIT_GATE] & (|ev_masked);
    next_st.maker_irq = mask[HLI_BIT_MAKER] & ev_eff[HLI_BIT_MAKER];
    next_st.soft_irq = mask[HLI_BIT_SOFT] & ev_eff[HLI_BIT_SOFT];
    // data stands only in the cycle after the strobe
    next_st.rd_data = HLI_RD_ZERO;
    if (bus.rd) begin
      unique case (bus.addr)
        HLI_OFS_EVT_SET, HLI_OFS_EVT_CLR: next_st.rd_data = ev_masked;
        HLI_OFS_MASK_SET, HLI_OFS_MASK_CLR: next_st.rd_data = mask;
        HLI_OFS_TXEV_SET: next_st.rd_data = {HLI_TX_PAD, tx_ev};
        HLI_OFS_TXEV_CLR: next_st.rd_data = {HLI_TX_PAD, tx_ev & tx_mask};
        HLI_OFS_TXMK_SET, HLI_OFS_TXMK_CLR: next_st.rd_data = {HLI_TX_PAD, tx_mask};
        default: next_st.rd_data = HLI_RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data             = st.rd_data;
  assign irq                 = st.irq;
  assign maker_extra_irq     = st.maker_irq;
  assign software_raised_irq = st.soft_irq;
  assign iso_tx_summary      = st.tx_sum;
  assign tx_context_flag     = tx_ev;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  AST_MASK_READ: assert property (
    bus.rd && (bus.addr == HLI_OFS_MASK_SET || bus.addr == HLI_OFS_MASK_CLR)
      |=> rd_data == $past(mask) && mask == $past(mask))
    else $error("mask read wrong or disturbed the mask");

  AST_MASK_SET: assert property (
    bus.wr && bus.addr == HLI_OFS_MASK_SET
      |=> (mask & $past(bus.wdata & HLI_MASK_RW)) == $past(bus.wdata & HLI_MASK_RW)
          && (mask & $past(mask)) == $past(mask))
    else $error("mask set write wrong");

  AST_MASK_CLR: assert property (
    bus.wr && bus.addr == HLI_OFS_MASK_CLR
      |=> (mask & $past(bus.wdata)) == HLI_RD_ZERO
          && mask == ($past(mask) & ~$past(bus.wdata)))
    else $error("mask clear write wrong");

  AST_MASK_RSVD: assert property (
    (mask & ~HLI_MASK_RW) == HLI_RD_ZERO)
    else $error("reserved mask bit set");

  AST_GATE_OFF: assert property (
    !mask[HLI_BIT_GATE] |=> !irq)
    else $error("interrupt with gate off");

  AST_IRQ_LEVEL: assert property (
    ##1 irq == $past(mask[HLI_BIT_GATE] && |(ev_eff & mask & HLI_MASK_RW)))
    else $error("interrupt level wrong");

  AST_MAKER: assert property (
    ##1 maker_extra_irq == $past(mask[HLI_BIT_MAKER] && main_event_in[HLI_BIT_MAKER]))
    else $error("maker interrupt wrong");

  AST_SOFT: assert property (
    ##1 software_raised_irq == $past(mask[HLI_BIT_SOFT] && main_event_in[HLI_BIT_SOFT]))
    else $error("software interrupt wrong");

  AST_TX_RISE: assert property (
    $rose(tx_ctx_irq[0]) |=> tx_ev[0])
    else $error("tx flag missed a request edge");

  AST_TX_HOLD: assert property (
    (|($past(tx_ev) & ~tx_ev)) |-> $past(bus.wr && bus.addr == HLI_OFS_TXEV_CLR))
    else $error("tx flag dropped without clear write");

  AST_TX_CLR_READ: assert property (
    bus.rd && bus.addr == HLI_OFS_TXEV_CLR |=> rd_data == {HLI_TX_PAD, $past(tx_ev & tx_mask)})
    else $error("tx clear read wrong");

  AST_TX_SUM: assert property (
    ##1 iso_tx_summary == $past(|(tx_ev & tx_mask)))
    else $error("tx summary wrong");

  AST_EVT_READ: assert property (
    bus.rd && bus.addr == HLI_OFS_EVT_CLR |=> (rd_data & ~$past(mask)) == HLI_RD_ZERO)
    else $error("event read not masked");

  AST_MASK_SET_EXACT: assert property (
    bus.wr && bus.addr == HLI_OFS_MASK_SET
      |=> mask == ($past(mask) | $past(bus.wdata & HLI_MASK_RW)))
    else $error("mask set write touched other bits");

  AST_MASK_HOLD: assert property (
    !(bus.wr && (bus.addr == HLI_OFS_MASK_SET || bus.addr == HLI_OFS_MASK_CLR))
      |=> mask == $past(mask))
    else $error("mask changed without a mask write");

  AST_GATE_SW_ONLY: assert property (
    $changed(mask[HLI_BIT_GATE])
      |-> $past(bus.wr && (bus.addr == HLI_OFS_MASK_SET || bus.addr == HLI_OFS_MASK_CLR)))
    else $error("gate bit moved without software");

  AST_MASK_RD_RSVD: assert property (
    bus.rd && (bus.addr == HLI_OFS_MASK_SET || bus.addr == HLI_OFS_MASK_CLR)
      |=> (rd_data & ~HLI_MASK_RW) == HLI_RD_ZERO)
    else $error("reserved mask bit read nonzero");

  AST_MAKER_OFF: assert property (
    !mask[HLI_BIT_MAKER] |=> !maker_extra_irq)
    else $error("maker interrupt while disabled");

  AST_SOFT_OFF: assert property (
    !mask[HLI_BIT_SOFT] |=> !software_raised_irq)
    else $error("software interrupt while disabled");

  AST_IRQ_QUIET: assert property (
    ev_masked == HLI_RD_ZERO |=> !irq)
    else $error("interrupt with nothing enabled pending");

  AST_TXSUM_IRQ: assert property (
    mask[HLI_BIT_GATE] && mask[HLI_BIT_ISOTX] && |(tx_ev & tx_mask) |=> irq)
    else $error("transmit summary gave no interrupt");

  AST_TX_SET: assert property (
    bus.wr && bus.addr == HLI_OFS_TXEV_SET
      |=> (tx_ev & $past(bus.wdata[7:0])) == $past(bus.wdata[7:0]))
    else $error("tx flag set write missed");

  AST_TX_CLR: assert property (
    bus.wr && bus.addr == HLI_OFS_TXEV_CLR
      |=> (tx_ev & $past(bus.wdata[7:0] & ~tx_rise)) == HLI_TX_RST)
    else $error("tx flag clear write missed");

  AST_TX_SET_READ: assert property (
    bus.rd && bus.addr == HLI_OFS_TXEV_SET |=> rd_data == {HLI_TX_PAD, $past(tx_ev)})
    else $error("tx flag read wrong");

  AST_TXMK_READ: assert property (
    bus.rd && (bus.addr == HLI_OFS_TXMK_SET || bus.addr == HLI_OFS_TXMK_CLR)
      |=> rd_data == {HLI_TX_PAD, $past(tx_mask)})
    else $error("tx mask read wrong");

  AST_TXMK_SET: assert property (
    bus.wr && bus.addr == HLI_OFS_TXMK_SET
      |=> tx_mask == ($past(tx_mask) | $past(bus.wdata[7:0])))
    else $error("tx mask set write wrong");

  AST_TXMK_CLR: assert property (
    bus.wr && bus.addr == HLI_OFS_TXMK_CLR
      |=> tx_mask == ($past(tx_mask) & ~$past(bus.wdata[7:0])))
    else $error("tx mask clear write wrong");

  AST_RD_IDLE: assert property (
    !bus.rd |=> rd_data == HLI_RD_ZERO)
    else $error("read data outside its cycle");

  // two checks per event position; bit 6 and the gate bit are built here
  for (genvar j = 0; j < HLI_DW; j++) begin : g_ev_chk
    if (j != HLI_BIT_ISOTX && j != HLI_BIT_GATE) begin : g_ev
      AST_EVT_BIT: assert property (
        @(posedge mclk) disable iff (srst)
        bus.rd && (bus.addr == HLI_OFS_EVT_SET || bus.addr == HLI_OFS_EVT_CLR)
          |=> rd_data[j] == $past(main_event_in[j] && mask[j]))
        else $error("masked event bit read wrong");

      AST_IRQ_BIT: assert property (
        @(posedge mclk) disable iff (srst)
        mask[HLI_BIT_GATE] && mask[j] && main_event_in[j] |=> irq)
        else $error("enabled event gave no interrupt");
    end
  end

  // per context: a request edge sets, only a clear write drops
  for (genvar c = 0; c < HLI_TXN; c++) begin : g_ctx_chk
    AST_TX_EDGE: assert property (
      @(posedge mclk) disable iff (srst)
      $rose(tx_ctx_irq[c]) |=> tx_ev[c])
      else $error("tx flag missed a request edge");

    AST_TX_STICKY: assert property (
      @(posedge mclk) disable iff (srst)
      tx_ev[c] && !(bus.wr && bus.addr == HLI_OFS_TXEV_CLR && bus.wdata[c]) |=> tx_ev[c])
      else $error("tx flag dropped without clear write");
  end

  CV_IRQ: cover property (mask[HLI_BIT_GATE] ##1 irq);
  CV_TX_FLOW: cover property ($rose(tx_ctx_irq[1]) ##2 iso_tx_summary);
  CV_TX_CLEAR: cover property (bus.wr && bus.addr == HLI_OFS_TXEV_CLR && |tx_ev);
  CV_SET_BEATS_CLR: cover property (
    bus.wr && bus.addr == HLI_OFS_TXEV_CLR && |(tx_rise & bus.wdata[7:0]));
  CV_GATE_BLOCK: cover property (!mask[HLI_BIT_GATE] && ev_masked != HLI_RD_ZERO);
endmodule : hli_irq_top
`default_nettype wire

// ### hli_pkg.sv
// Purpose: shared constants and types for the interrupt gating block
// Assumes: one 20 MHz clock, plain strobe register port
// Notes:   offsets are byte addresses on an 8-bit address port
package hli_pkg;
  localparam int unsigned HLI_DW  = 32;
  localparam int unsigned HLI_AW  = 8;
  localparam int unsigned HLI_TXN = 8;

  // register byte offsets
  localparam logic [7:0] HLI_OFS_EVT_SET  = 8'h80;
  localparam logic [7:0] HLI_OFS_EVT_CLR  = 8'h84;
  localparam logic [7:0] HLI_OFS_MASK_SET = 8'h88;
  localparam logic [7:0] HLI_OFS_MASK_CLR = 8'h8c;
  localparam logic [7:0] HLI_OFS_TXEV_SET = 8'h90;
  localparam logic [7:0] HLI_OFS_TXEV_CLR = 8'h94;
  localparam logic [7:0] HLI_OFS_TXMK_SET = 8'h98;
  localparam logic [7:0] HLI_OFS_TXMK_CLR = 8'h9c;

  // bit positions in the mask and main event words
  localparam int unsigned HLI_BIT_GATE  = 31;
  localparam int unsigned HLI_BIT_MAKER = 30;
  localparam int unsigned HLI_BIT_SOFT  = 29;
  localparam int unsigned HLI_BIT_ISOTX = 6;

  // writable mask bits: 28 and 14..10 are reserved
  localparam logic [31:0] HLI_MASK_RW  = 32'hefff_83ff;
  localparam logic [31:0] HLI_MASK_RST = 32'h0000_0000;
  localparam logic [7:0]  HLI_TX_RW    = 8'hff;
  localparam logic [7:0]  HLI_TX_RST   = 8'h00;
  localparam logic [31:0] HLI_RD_ZERO  = 32'h0000_0000;
  localparam logic [23:0] HLI_TX_PAD   = 24'h00_0000;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } hli_bus_t;

  typedef struct packed {
    logic        irq;
    logic        maker_irq;
    logic        soft_irq;
    logic        tx_sum;
    logic [31:0] rd_data;
  } hli_top_st_t;
endpackage : hli_pkg

// ### hli_edge_det.sv
// Purpose: per-bit rising edge detector for context interrupt requests
// Assumes: inputs synchronous to mclk
// Notes:   a request already high at reset release counts as an edge
`timescale 1ns/1ns
`default_nettype none
module hli_edge_det
  import hli_pkg::*;
#(
  parameter int unsigned W = 8
) (
  input  wire logic         mclk,  // clock
  input  wire logic         srst,  // sync reset
  input  wire logic [W-1:0] lvl,   // request levels
  output logic      [W-1:0] rise   // one-cycle edge pulses
);
  typedef struct packed {
    logic [W-1:0] prev;
  } hli_edge_st_t;

  hli_edge_st_t st;
  hli_edge_st_t next_st;

  always_comb begin
    next_st.prev = lvl;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st.prev <= '0;
    end else begin
      st <= next_st;
    end
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    assign rise[i] = lvl[i] & ~st.prev[i];
  end
endmodule : hli_edge_det
`default_nettype wire

// ### hli_setclr_reg.sv
// Purpose: set/clear register with write-one semantics and hardware set
// Assumes: sw set and clear never in the same cycle
// Notes:   a hardware set beats a clear in the same cycle
`timescale 1ns/1ns
`default_nettype none
module hli_setclr_reg
  import hli_pkg::*;
#(
  parameter int unsigned    W   = 32,
  parameter logic [W-1:0]   RW  = '1,
  parameter logic [W-1:0]   RST = '0
) (
  input  wire logic         mclk,    // clock
  input  wire logic         srst,    // sync reset
  input  wire logic [W-1:0] sw_set,  // write-one set
  input  wire logic [W-1:0] sw_clr,  // write-one clear
  input  wire logic [W-1:0] hw_set,  // hardware set pulses
  output logic      [W-1:0] q        // current contents
);
  typedef struct packed {
    logic [W-1:0] val;
  } hli_scr_st_t;

  hli_scr_st_t st;
  hli_scr_st_t next_st;

  always_comb begin
    // set terms applied after the clear so an event is never lost
    next_st.val = ((st.val & ~sw_clr) | sw_set | hw_set) & RW;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st.val <= RST;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.val;
endmodule : hli_setclr_reg
`default_nettype wire

// ### testbench.sv
// Purpose: self-checking bench for the interrupt mask and transmit event logic
// Assumes: bus driven by non-blocking assignment just after the rising edge
// Notes:   a cycle model beside the design is compared on every falling edge after the first reset
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import hli_pkg::*;
  logic        mclk;
  logic        srst;
  hli_bus_t    bus;
  logic [31:0] rd_data;
  logic [31:0] main_event_in;
  logic [7:0]  tx_ctx_irq;
  logic        irq;
  logic        maker_extra_irq;
  logic        software_raised_irq;
  logic        iso_tx_summary;
  logic [7:0]  tx_context_flag;
  int          fails;
  int          comparisons;
  logic        chk_on;
  logic [31:0] st;
  // cycle model state
  logic [31:0] m_mask, m_rd, ev;
  logic [7:0]  m_txm, m_flg, m_prev, rise, tset, tclr;
  logic        m_irq, m_mk, m_sf, m_sum, s;
  logic [7:0]  amap [10];

  hli_irq_top i_dut (
    .mclk                (mclk),
    .srst                (srst),
    .bus                 (bus),
    .rd_data             (rd_data),
    .main_event_in       (main_event_in),
    .tx_ctx_irq          (tx_ctx_irq),
    .irq                 (irq),
    .maker_extra_irq     (maker_extra_irq),
    .software_raised_irq (software_raised_irq),
    .iso_tx_summary      (iso_tx_summary),
    .tx_context_flag     (tx_context_flag)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction : lfsr

  function automatic logic [31:0] rd_val(input logic [7:0] a);
    case (a)
      8'h80, 8'h84: return ev & m_mask;
      8'h88, 8'h8c: return m_mask;
      8'h90:        return {24'h00_0000, m_flg};
      8'h94:        return {24'h00_0000, m_flg & m_txm};
      8'h98, 8'h9c: return {24'h00_0000, m_txm};
      default:      return 32'h0000_0000;
    endcase
  endfunction : rd_val

  // model sees inputs as they stood before the edge, like the design
  always @(posedge mclk) begin
    if (srst) begin
      {m_mask, m_txm, m_flg, m_prev, m_rd} <= '0;
      {m_irq, m_mk, m_sf, m_sum} <= '0;
    end else begin
      rise = tx_ctx_irq & ~m_prev;
      s = |(m_flg & m_txm);
      ev = main_event_in;
      ev[6] = s;
      ev[31] = 1'b0;
      m_irq <= m_mask[31] & (|(ev & m_mask));
      m_mk <= m_mask[30] & ev[30];
      m_sf <= m_mask[29] & ev[29];
      m_sum <= s;
      m_rd <= bus.rd ? rd_val(bus.addr) : 32'h0000_0000;
      m_prev <= tx_ctx_irq;
      tset = (bus.wr && bus.addr == 8'h90) ? bus.wdata[7:0] : 8'h00;
      tclr = (bus.wr && bus.addr == 8'h94) ? bus.wdata[7:0] : 8'h00;
      m_flg <= (m_flg | tset | rise) & ~(tclr & ~rise);
      if (bus.wr && bus.addr == 8'h88) m_mask <= m_mask | (bus.wdata & HLI_MASK_RW);
      if (bus.wr && bus.addr == 8'h8c) m_mask <= m_mask & ~bus.wdata;
      if (bus.wr && bus.addr == 8'h98) m_txm <= m_txm | bus.wdata[7:0];
      if (bus.wr && bus.addr == 8'h9c) m_txm <= m_txm & ~bus.wdata[7:0];
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  always @(negedge mclk) begin
    if (chk_on) begin
      check("irq", 32'(irq), 32'(m_irq));
      check("maker_extra_irq", 32'(maker_extra_irq), 32'(m_mk));
      check("software_raised_irq", 32'(software_raised_irq), 32'(m_sf));
      check("iso_tx_summary", 32'(iso_tx_summary), 32'(m_sum));
      check("tx_context_flag", 32'(tx_context_flag), 32'(m_flg));
      check("rd_data", rd_data, m_rd);
    end
  end

  // one strobe cycle, then one idle cycle so no signal is assigned twice at one edge
  task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= w;
    bus.rd <= ~w;
    @(posedge mclk);
    bus.wr <= 1'b0;
    bus.rd <= 1'b0;
    @(posedge mclk);
  endtask : op

  task automatic read_all();
    for (int k = 0; k < 10; k++) op(1'b0, amap[k], 32'h0000_0000);
  endtask : read_all

  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  initial begin
    repeat (100000) @(posedge mclk);
    fails++;
    stop_test();
  end

  initial begin
    amap = '{8'h80, 8'h84, 8'h88, 8'h8c, 8'h90, 8'h94, 8'h98, 8'h9c, 8'h44, 8'ha0};
    bus = '0;
    main_event_in = 32'h0000_0000;
    tx_ctx_irq = 8'h00;
    srst = 1'b1;
    chk_on = 1'b0;
    fails = 0;
    comparisons = 0;
    st = 32'ha2ddc964;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    chk_on <= 1'b1;
    @(posedge mclk);
    read_all();
    $display("test reset_values done");
    op(1'b1, 8'h98, 32'h0000_0001);
    op(1'b1, 8'h88, 32'h8000_0040);
    tx_ctx_irq <= 8'h01;
    repeat (4) @(posedge mclk);
    op(1'b1, 8'h94, 32'h0000_0001);
    read_all();
    $display("test tx_summary_walk done");
    op(1'b1, 8'h88, 32'hffff_ffff);
    main_event_in <= 32'hffff_ffff;
    tx_ctx_irq <= 8'h00;
    read_all();
    op(1'b1, 8'h8c, 32'h8000_0000);
    repeat (6) @(posedge mclk);
    op(1'b1, 8'h44, 32'hffff_ffff);
    op(1'b1, 8'h80, 32'h0000_0000);
    read_all();
    $display("test gate_and_reserved done");
    tx_ctx_irq <= 8'h09;
    op(1'b1, 8'h94, 32'h0000_0009);
    op(1'b1, 8'h90, 32'h0000_00f0);
    op(1'b1, 8'h94, 32'h0000_00ff);
    read_all();
    $display("test set_beats_clear done");
    for (int i = 0; i < 3000; i++) begin
      st = lfsr(st);
      main_event_in <= st ^ {st[15:0], st[31:16]};
      if (st[3]) tx_ctx_irq <= st[15:8];
      op(st[4], amap[st[31:28] % 10], lfsr(st));
    end
    $display("test random_traffic done");
    srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    read_all();
    $display("test second_reset done");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
